// ### bench/dccb_core_props.sv
// Port-level checker of the capture/compare block
module dccb_core_props (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Register port
  input wire logic [5:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Events and port settings
  input wire logic TICK,
  input wire logic [3:0] CAPTURE_IN,
  input wire logic WAKEUP_INPUT_4_N,
  input wire logic WAKEUP_SEL,
  input wire logic [7:0] PORT_DIRECTION,
  input wire logic [7:0] PORT_DATA,
  // Pins and request
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE,
  input wire logic TIMER_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire cap_any = |CAPTURE_IN;
  wire port_view = (PIN_OUT == PORT_DATA) && (PIN_OE == PORT_DIRECTION);
  // Both enable words cleared, one idle cycle apart
  sequence ien_off;
    WR && ADDR == 6'h07 && WDATA == 16'h0000 ##2 WR && ADDR == 6'h0F && WDATA == 16'h0000;
  endsequence
  sequence wake_trip;
    WAKEUP_SEL && !WAKEUP_INPUT_4_N;
  endsequence
  a_rdata_hold: assert property (!$past(RD) |-> $stable(RDATA))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (RD && ADDR == 6'h3F |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_status_bits: assert property (
    RD && (ADDR == 6'h06 || ADDR == 6'h0E) |=> (RDATA & 16'hFFCC) == 16'h0000)
    else $error("status read shows unused bits");
  a_master_off: assert property (WR && ADDR == 6'h11 && WDATA[0] |-> ##2 port_view)
    else $error("pins not handed to port");
  a_reset_off: assert property ($fell(RESET) |-> port_view)
    else $error("pins not on port after reset");
  a_wake_trip: assert property (wake_trip |-> ##[1:3] port_view)
    else $error("wake-up trip left outputs on");
  a_irq_cause: assert property ($rose(TIMER_IRQ) |->
    $past(WR) || $past(WR, 2) || $past(TICK) || $past(TICK, 2) || $past(cap_any)
    || $past(cap_any, 2))
    else $error("request rose without cause");
  a_irq_off: assert property (ien_off |-> ##2 !TIMER_IRQ)
    else $error("request stays with enables off");
endmodule // dccb_core_props

bind dccb_core dccb_core_props i_dccb_core_props (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TICK(TICK), .CAPTURE_IN(CAPTURE_IN),
  .WAKEUP_INPUT_4_N(WAKEUP_INPUT_4_N), .WAKEUP_SEL(WAKEUP_SEL),
  .PORT_DIRECTION(PORT_DIRECTION), .PORT_DATA(PORT_DATA), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .TIMER_IRQ(TIMER_IRQ)
);

// ### bench/dccb_core_test.sv
// Self-checking bench of the capture/compare block
module dccb_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [5:0] ADDR = 6'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic TICK = 1'b0;
  logic WAKEUP_SEL = 1'b0;
  logic [7:0] PORT_DIRECTION = 8'hA5;
  logic [7:0] PORT_DATA = 8'h3C;
  logic [3:0] fire = 4'h0;
  logic [3:0] lag = 4'h1;
  logic trip = 1'b0;
  logic [7:0] v;
  int fails = 0;
  int tests_run = 0;
  wire logic [15:0] RDATA;
  wire logic [3:0] CAPTURE_IN;
  wire logic WAKEUP_INPUT_4_N;
  wire logic [7:0] PIN_OUT;
  wire logic [7:0] PIN_OE;
  wire logic TIMER_IRQ;
  always #20 SYS_CLK = ~SYS_CLK;
  dccb_core i_dccb_core (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TICK(TICK), .CAPTURE_IN(CAPTURE_IN),
    .WAKEUP_INPUT_4_N(WAKEUP_INPUT_4_N), .WAKEUP_SEL(WAKEUP_SEL),
    .PORT_DIRECTION(PORT_DIRECTION), .PORT_DATA(PORT_DATA), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .TIMER_IRQ(TIMER_IRQ)
  );
  dccb_far_end i_dccb_far_end (
    .sys_clk(SYS_CLK), .fire(fire), .lag(lag), .trip(trip),
    .capture_in(CAPTURE_IN), .wakeup_n(WAKEUP_INPUT_4_N)
  );
  task automatic finish_test;
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [15:0] e, input string n);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 chk(n, e, RDATA);
  endtask
  task automatic pk(input string n, input logic [7:0] e, input logic [7:0] m);
    @(posedge SYS_CLK);
    #1 chk(n, {8'h00, e & m}, {8'h00, PIN_OUT & m});
  endtask
  task automatic snap;
    @(posedge SYS_CLK);
    #1 v = PIN_OUT;
  endtask
  task automatic tk;
    @(posedge SYS_CLK);
    TICK <= 1'b1;
    @(posedge SYS_CLK);
    TICK <= 1'b0;
  endtask
  task automatic cp(input logic [3:0] m);
    @(posedge SYS_CLK);
    fire <= m;
    @(posedge SYS_CLK);
    fire <= 4'h0;
    repeat (lag + 2) @(posedge SYS_CLK);
  endtask
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fails++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    #1 chk("oe", {8'h00, PORT_DIRECTION}, {8'h00, PIN_OE});
    chk("irq", 16'h0000, {15'h0000, TIMER_IRQ});
    rc(6'h3F, 16'h0000, "unmapped");
    wr(6'h01, 16'h1234);
    rc(6'h01, 16'h1234, "cca");
    // Channel 0 register A captures, buffered into C
    wr(6'h05, 16'h0005);
    wr(6'h00, 16'h0100);
    cp(4'h1);
    rc(6'h01, 16'h0100, "cap a");
    rc(6'h03, 16'h1234, "shadow c");
    lag <= 4'h5;
    wr(6'h00, 16'h0200);
    cp(4'h1);
    rc(6'h01, 16'h0200, "cap a2");
    rc(6'h03, 16'h0100, "shadow c2");
    // Zero written before any status read must not clear
    wr(6'h06, 16'h0000);
    rc(6'h06, 16'h0001, "status");
    wr(6'h07, 16'h0001);
    pk("irq on", 8'h00, 8'h00);
    chk("irq on", 16'h0001, {15'h0000, TIMER_IRQ});
    wr(6'h07, 16'h0000);
    wr(6'h0F, 16'h0000);
    pk("irq off", 8'h00, 8'h00);
    chk("irq off", 16'h0000, {15'h0000, TIMER_IRQ});
    wr(6'h06, 16'h0000);
    rc(6'h06, 16'h0000, "cleared");
    // Wrap from the top count
    wr(6'h00, 16'hFFFF);
    wr(6'h13, 16'h0001);
    tk;
    wr(6'h13, 16'h0000);
    rc(6'h00, 16'h0000, "wrap");
    rc(6'h06, 16'h0012, "ovf");
    // Channel 1 compare with buffer C into A
    wr(6'h0D, 16'h0004);
    wr(6'h09, 16'h0005);
    wr(6'h0B, 16'h0077);
    wr(6'h08, 16'h0004);
    wr(6'h13, 16'h0002);
    tk;
    rc(6'h0E, 16'h0000, "early");
    tk;
    wr(6'h13, 16'h0000);
    rc(6'h09, 16'h0077, "cmp a");
    rc(6'h0E, 16'h0001, "match");
    // Polarity in plain PWM on both channels
    wr(6'h11, 16'h0000);
    wr(6'h10, 16'h00C0);
    snap;
    wr(6'h12, 16'h00EE);
    pk("pol", ~v, 8'hEE);
    wr(6'h12, 16'h0000);
    for (int m = 2; m < 4; m++) begin
      wr(6'h10, 16'h0000);
      wr(6'h10, 16'(m));
      snap;
      wr(6'h10, 16'(m) | 16'h0030);
      pk("level", ~v, 8'hFA);
    end
    wr(6'h10, 16'h0000);
    @(posedge SYS_CLK);
    WAKEUP_SEL <= 1'b1;
    trip <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1 chk("wake oe", {8'h00, PORT_DIRECTION}, {8'h00, PIN_OE});
    rc(6'h11, 16'h0001, "wake reg");
    @(posedge SYS_CLK);
    trip <= 1'b0;
    WAKEUP_SEL <= 1'b0;
    wr(6'h11, 16'h0000);
    wr(6'h11, 16'h0001);
    pk("port", PORT_DATA, 8'hFF);
    finish_test;
  end
endmodule // dccb_core_test

// ### bench/dccb_far_end.sv
// Far-side model: capture pulses after a lag, and the wake-up line
module dccb_far_end (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic [3:0] fire,
  input wire logic [3:0] lag,
  input wire logic trip,
  // Lines into the block
  output logic [3:0] capture_in,
  output logic wakeup_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] held = 4'h0;
  logic [3:0] cnt = 4'h0;
  initial capture_in = 4'h0;
  // Line idles high and is driven low while trip is one
  assign wakeup_n = !trip;
  // Lag one pulses two cycles after the request; each larger lag adds a cycle
  always @(posedge sys_clk) begin
    capture_in <= 4'h0;
    if (|fire) begin
      held <= fire;
      cnt <= lag;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) capture_in <= held;
    end
  end
endmodule // dccb_far_end

// ### hw/dccb_core.sv
// Two-channel 16-bit capture/compare timer with buffering, gating and flags
// Notes on behaviour
// - Compare match copies shadow into general register
// - Capture loads count, old value to shadow
// - Complementary: transfer at cycle match, ch1 underflow
// - Reset-sync: transfer only on ch0 A match
// - Shadow D >= cycle: transfer on underflow only
// - Shadow D zero: transfer on cycle match only
// - Master enable one hands pins to port
// - Low wake-up input sets master enable bit
// - Level select bits at zero invert reset-sync and complementary PWM outputs
// - Plain PWM polarity bits invert pins B-D
// - Interrupt when flag and enable both one
// - Match flagged at counter tick ending match
// - Capture sets flag and copies count together
// - Overflow flag on wrap from max to zero
// - Flag clears on zero write after reading one
// - Clear beats counter write in second state
// - Register write suppresses same-state compare match
// - Counter write beats increment, overflow still flagged
// - Read returns pre-capture register contents
// - Capture clear beats increment, old count captured
// - Capture beats register write in second state
// - A pairs with C, B pairs with D
// - Complementary: down after match, up after underflow
//
// The implementer's own choices: the register offsets and the strobed register port.
module dccb_core import dccb_pkg::*; (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Register port
  input wire logic [5:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Counter clock enable and capture inputs, per channel pins A and B
  input wire logic TICK,
  input wire logic [3:0] CAPTURE_IN,
  // Wake-up input
  input wire logic WAKEUP_INPUT_4_N,
  input wire logic WAKEUP_SEL,
  // General purpose port settings
  input wire logic [7:0] PORT_DIRECTION,
  input wire logic [7:0] PORT_DATA,
  // Pins: ch0 A-D then ch1 A-D
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic TIMER_IRQ
);
  `include "dccb_defs.svh"

  logic [15:0] cnt_reg [2];
  logic [15:0] cca_reg [2];
  logic [15:0] ccb_reg [2];
  logic [15:0] shc_reg [2];
  logic [15:0] shd_reg [2];
  logic [15:0] ctrl_reg [2];
  logic [15:0] status_reg [2];
  logic [15:0] ien_reg [2];
  logic [15:0] seen_reg [2];
  logic [15:0] func_reg;
  logic [15:0] omen_reg;
  logic [15:0] pol_reg;
  logic [1:0] start_reg;
  logic [1:0] down_reg;
  logic [3:0] wave_reg [2];
  logic [15:0] rdata_reg;
  dccb_bus_state_e bus_state_reg;
  dccb_bus_req_s req_reg;

  // Selected channel and register of an address
  function automatic logic [2:0] reg_sel(input logic [5:0] a);
    reg_sel = a[2:0];
  endfunction
  function automatic logic hits(input logic [5:0] a, input int ch, input logic [5:0] ofs);
    hits = (a[5:3] == 3'(ch)) && (a[2:0] == ofs[2:0]);
  endfunction

  dccb_mode_e mode;
  assign mode = dccb_mode_e'(func_reg[`DCCB_FN_CMD_LO +: 2]);
  wire compl_mode = (mode == DCCB_COMPL_PWM);
  wire rsync_mode = (mode == DCCB_RESET_PWM);
  wire wr_t2 = (bus_state_reg == DCCB_T2_WRITE);

  // Per-channel event wires
  logic [1:0] tick_en, match_a, match_b, cap_a, cap_b, ovf, underflow_flag, clr;
  logic [15:0] cnt_next [2];
  logic [1:0] wr_cnt, wr_cca, wr_ccb;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire run = start_reg[g] && TICK;
      assign tick_en[g] = run;
      wire a_is_cap = ctrl_reg[g][`DCCB_CT_CAPA] && !compl_mode && !rsync_mode;
      wire b_is_cap = ctrl_reg[g][`DCCB_CT_CAPB] && !compl_mode && !rsync_mode;
      assign wr_cnt[g] = wr_t2 && hits(req_reg.addr, g, `DCCB_OFS_COUNT);
      assign wr_cca[g] = wr_t2 && hits(req_reg.addr, g, `DCCB_OFS_CCA);
      assign wr_ccb[g] = wr_t2 && hits(req_reg.addr, g, `DCCB_OFS_CCB);
      // Match is flagged on the tick that ends the matching count
      // A register write in the same state suppresses it
      assign match_a[g] = run && !a_is_cap && (cnt_reg[g] == cca_reg[g]) && !wr_cca[g];
      assign match_b[g] = run && !b_is_cap && (cnt_reg[g] == ccb_reg[g]) && !wr_ccb[g];
      assign cap_a[g] = a_is_cap && CAPTURE_IN[2*g];
      assign cap_b[g] = b_is_cap && CAPTURE_IN[2*g+1];
      wire up_wrap = run && !down_reg[g] && (cnt_reg[g] == `DCCB_CNT_MAX);
      wire dn_wrap = run && down_reg[g] && (cnt_reg[g] == `DCCB_CNT_ZERO);
      assign ovf[g] = up_wrap;
      assign underflow_flag[g] = dn_wrap;
      assign clr[g] = !compl_mode && ((ctrl_reg[g][`DCCB_CT_CLRA] && match_a[g])
        || (ctrl_reg[g][`DCCB_CT_CLRB] && match_b[g])
        || (ctrl_reg[g][`DCCB_CT_CLRCAPB] && cap_b[g])
        || (rsync_mode && g == 0 && match_a[0]));
      // Clear beats write and increment; write beats increment
      always_comb begin
        if (clr[g]) begin
          cnt_next[g] = `DCCB_CNT_ZERO;
        end else if (wr_cnt[g]) begin
          cnt_next[g] = req_reg.data;
        end else if (run) begin
          cnt_next[g] = down_reg[g] ? cnt_reg[g] - 16'h0001 : cnt_reg[g] + 16'h0001;
        end else begin
          cnt_next[g] = cnt_reg[g];
        end
      end
    end
  endgenerate

  // Shadow-to-general transfer strobes
  wire cyc_match = match_a[0] && compl_mode;
  logic [1:0] xfer_a, xfer_b;
  wire d0_ge = shd_reg[0] >= cca_reg[0];
  wire d0_zero = shd_reg[0] == `DCCB_CNT_ZERO;
  wire compl_xfer = cyc_match || underflow_flag[1];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (compl_mode) begin
        xfer_a[c] = compl_xfer;
        xfer_b[c] = compl_xfer;
      end else if (rsync_mode) begin
        xfer_a[c] = match_a[0];
        xfer_b[c] = match_a[0];
      end else begin
        xfer_a[c] = match_a[c];
        xfer_b[c] = match_b[c];
      end
    end
    if (compl_mode && d0_ge) begin
      xfer_b[0] = underflow_flag[1];
    end else if (compl_mode && d0_zero) begin
      xfer_b[0] = cyc_match;
    end
  end

  // Bus: first state latches the request, second commits a write
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      bus_state_reg <= DCCB_IDLE;
      req_reg <= '0;
    end else begin
      bus_state_reg <= WR ? DCCB_T2_WRITE : DCCB_IDLE;
      req_reg <= '{addr: ADDR, data: WDATA};
    end
  end

  // Read data is taken from register values before any capture this state
  logic [15:0] rd_mux;
  wire [2:0] rch = ADDR[5:3];
  wire rc = ADDR[3];
  always_comb begin
    rd_mux = 16'h0000;
    if (rch < 3'h2) begin
      unique case (reg_sel(ADDR))
        3'h0: rd_mux = cnt_reg[rc];
        3'h1: rd_mux = cca_reg[rc];
        3'h2: rd_mux = ccb_reg[rc];
        3'h3: rd_mux = shc_reg[rc];
        3'h4: rd_mux = shd_reg[rc];
        3'h5: rd_mux = ctrl_reg[rc];
        3'h6: rd_mux = status_reg[rc];
        3'h7: rd_mux = ien_reg[rc];
      endcase
    end else if (ADDR == `DCCB_OFS_FUNC) begin
      rd_mux = func_reg;
    end else if (ADDR == `DCCB_OFS_OMEN) begin
      rd_mux = omen_reg;
    end else if (ADDR == `DCCB_OFS_POL) begin
      rd_mux = pol_reg;
    end else if (ADDR == `DCCB_OFS_START) begin
      rd_mux = {14'h0000, start_reg};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= 16'h0000;
    end else if (RD) begin
      rdata_reg <= rd_mux;
    end
  end
  assign RDATA = rdata_reg;

  // Global registers
  wire wake_trip = WAKEUP_SEL && !WAKEUP_INPUT_4_N;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      func_reg <= 16'h0000;
      omen_reg <= `DCCB_RST_OMEN;
      pol_reg <= 16'h0000;
      start_reg <= 2'b00;
    end else begin
      if (wr_t2 && req_reg.addr == `DCCB_OFS_FUNC) func_reg <= req_reg.data;
      if (wake_trip) begin
        omen_reg[0] <= 1'b1;
      end else if (wr_t2 && req_reg.addr == `DCCB_OFS_OMEN) begin
        omen_reg <= {15'h0000, req_reg.data[0]};
      end
      if (wr_t2 && req_reg.addr == `DCCB_OFS_POL) pol_reg <= req_reg.data;
      if (wr_t2 && req_reg.addr == `DCCB_OFS_START) start_reg <= req_reg.data[1:0];
    end
  end

  // Per-channel registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int c = 0; c < 2; c++) begin
        cnt_reg[c] <= 16'h0000;
        cca_reg[c] <= 16'hFFFF;
        ccb_reg[c] <= 16'hFFFF;
        shc_reg[c] <= 16'hFFFF;
        shd_reg[c] <= 16'hFFFF;
        ctrl_reg[c] <= 16'h0000;
        status_reg[c] <= 16'h0000;
        ien_reg[c] <= 16'h0000;
        seen_reg[c] <= 16'h0000;
        wave_reg[c] <= 4'h0;
      end
      down_reg <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        cnt_reg[c] <= cnt_next[c];
        // Capture wins over write old value moves to shadow
        if (cap_a[c]) begin
          cca_reg[c] <= cnt_reg[c];
          if (ctrl_reg[c][`DCCB_CT_BUFA]) shc_reg[c] <= cca_reg[c];
        end else if (ctrl_reg[c][`DCCB_CT_BUFA] && xfer_a[c]) begin
          cca_reg[c] <= shc_reg[c];
        end else if (wr_cca[c]) begin
          cca_reg[c] <= req_reg.data;
        end
        if (cap_b[c]) begin
          ccb_reg[c] <= cnt_reg[c];
          if (ctrl_reg[c][`DCCB_CT_BUFB]) shd_reg[c] <= ccb_reg[c];
        end else if (ctrl_reg[c][`DCCB_CT_BUFB] && xfer_b[c]) begin
          ccb_reg[c] <= shd_reg[c];
        end else if (wr_ccb[c]) begin
          ccb_reg[c] <= req_reg.data;
        end
        if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_SHC) && !(cap_a[c] && ctrl_reg[c][`DCCB_CT_BUFA]))
          shc_reg[c] <= req_reg.data;
        if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_SHD) && !(cap_b[c] && ctrl_reg[c][`DCCB_CT_BUFB]))
          shd_reg[c] <= req_reg.data;
        if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_CTRL)) ctrl_reg[c] <= req_reg.data;
        if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_IEN)) ien_reg[c] <= req_reg.data;
        // Remember flags read as one; a zero write clears only those
        if (RD && hits(ADDR, c, `DCCB_OFS_STATUS))
          seen_reg[c] <= status_reg[c];
        begin : flags
          logic [15:0] keep;
          logic [15:0] setv;
          keep = status_reg[c];
          if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_STATUS))
            keep = status_reg[c] & (req_reg.data | ~seen_reg[c]);
          setv = 16'h0000;
          setv[`DCCB_ST_MFA] = match_a[c] || cap_a[c];
          setv[`DCCB_ST_MFB] = match_b[c] || cap_b[c];
          setv[`DCCB_ST_OVF] = ovf[c];
          setv[`DCCB_ST_UDF] = underflow_flag[c];
          status_reg[c] <= (keep | setv) & `DCCB_ST_MASK;
          if (wr_t2 && hits(req_reg.addr, c, `DCCB_OFS_STATUS)) seen_reg[c] <= 16'h0000;
        end
        // Waveforms: toggle on match, restart at clear
        if (clr[c]) wave_reg[c] <= 4'h0;
        else wave_reg[c] <= wave_reg[c] ^ {match_b[c], match_a[c], match_b[c], match_a[c]};
      end
      // Direction reversal in complementary mode
      if (!compl_mode) begin
        down_reg <= 2'b00;
      end else if (cyc_match) begin
        down_reg <= 2'b11;
      end else if (underflow_flag[1]) begin
        down_reg <= 2'b00;
      end
    end
  end

  // Interrupt request
  assign TIMER_IRQ = |(status_reg[0] & ien_reg[0]) || |(status_reg[1] & ien_reg[1]);

  // Output gating and polarity
  logic [7:0] raw_wave, shaped;
  wire pwm_sync = compl_mode || rsync_mode;
  wire [3:0] lvl = {func_reg[`DCCB_FN_OLS_LO], func_reg[`DCCB_FN_OLS_HI],
                    func_reg[`DCCB_FN_OLS_LO], func_reg[`DCCB_FN_OLS_HI]};
  wire [1:0] plain_pwm = {func_reg[`DCCB_FN_PWM1], func_reg[`DCCB_FN_PWM0]};
  always_comb begin
    raw_wave = {wave_reg[1], wave_reg[0]};
    shaped = raw_wave;
    if (pwm_sync) begin
      shaped = raw_wave ^ {~lvl, ~lvl};
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (plain_pwm[c]) shaped[4*c+1 +: 3] = raw_wave[4*c+1 +: 3] ^ pol_reg[4*c+1 +: 3];
      end
    end
  end
  wire disabled = omen_reg[0];
  // Port settings take the pins while the master bit is one
  assign PIN_OUT = disabled ? PORT_DATA : shaped;
  assign PIN_OE = disabled ? PORT_DIRECTION : 8'hFF;
endmodule // dccb_core

// ### hw/dccb_defs.svh
// Register offsets, field positions and reset values of the capture/compare block
`ifndef DCCB_DEFS_SVH
`define DCCB_DEFS_SVH
`define DCCB_AW 6
// Register word offsets: channel n registers at base + n*8
`define DCCB_OFS_COUNT 6'h00
`define DCCB_OFS_CCA 6'h01
`define DCCB_OFS_CCB 6'h02
`define DCCB_OFS_SHC 6'h03
`define DCCB_OFS_SHD 6'h04
`define DCCB_OFS_CTRL 6'h05
`define DCCB_OFS_STATUS 6'h06
`define DCCB_OFS_IEN 6'h07
`define DCCB_CH_STRIDE 6'h08
`define DCCB_OFS_FUNC 6'h10
`define DCCB_OFS_OMEN 6'h11
`define DCCB_OFS_POL 6'h12
`define DCCB_OFS_START 6'h13
// Channel control fields
`define DCCB_CT_CAPA 0
`define DCCB_CT_CAPB 1
`define DCCB_CT_BUFA 2
`define DCCB_CT_BUFB 3
`define DCCB_CT_CLRA 4
`define DCCB_CT_CLRB 5
`define DCCB_CT_CLRCAPB 6
// Status and enable fields
`define DCCB_ST_MFA 0
`define DCCB_ST_MFB 1
`define DCCB_ST_OVF 4
`define DCCB_ST_UDF 5
`define DCCB_ST_MASK 16'h0033
// Function control fields
`define DCCB_FN_CMD_LO 0
`define DCCB_FN_OLS_LO 4
`define DCCB_FN_OLS_HI 5
`define DCCB_FN_PWM0 6
`define DCCB_FN_PWM1 7
`define DCCB_RST_OMEN 16'h0001
`define DCCB_CNT_MAX 16'hFFFF
`define DCCB_CNT_ZERO 16'h0000
`endif

// ### hw/dccb_pkg.sv
// Types shared by the capture/compare block
package dccb_pkg;
  typedef enum logic [1:0] {DCCB_NORMAL, DCCB_RSVD, DCCB_RESET_PWM, DCCB_COMPL_PWM} dccb_mode_e;
  typedef enum {DCCB_IDLE, DCCB_T2_WRITE} dccb_bus_state_e;
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] data;
  } dccb_bus_req_s;
  typedef struct packed {
    logic [3:0] cap;
    logic [3:0] cmp;
  } dccb_pins_s;
endpackage
